// ===== logic/rivp_defines.svh
// Purpose: constants for reset and interrupt vector placement
// Assumes: word addressed program memory
// Notes: vector n sits at table origin + 2*(n-1)
`ifndef RIVP_DEFINES_SVH
`define RIVP_DEFINES_SVH

`define RIVP_ADDR_W 17
`define RIVP_NUM_REQ 56
`define RIVP_FIRST_REQ_VEC 6'h02
`define RIVP_LAST_VEC 6'h39
`define RIVP_APP_RESET_ADDR 17'h00000
`define RIVP_VEC_START_OFF 17'h00002
`define RIVP_LARGE_ONLY_MASK 56'hfc_2100_0000_0000
`define RIVP_FUSE_PROGRAMMED 1'h0

`endif

// ===== logic/rivp_pkg.sv
// Purpose: shared types for reset and interrupt vector placement
// Assumes: rivp_defines.svh on the include path
// Notes: none
`include "rivp_defines.svh"

package rivp_pkg;

  typedef logic [`RIVP_ADDR_W-1:0] rivp_addr_t;
  typedef logic [`RIVP_NUM_REQ-1:0] rivp_req_t;
  typedef logic [5:0] rivp_num_t;

  typedef struct packed {
    logic valid;
    rivp_num_t num;
    rivp_addr_t addr;
  } rivp_vec_s;

endpackage

// ===== logic/rivp_top.sv
// Purpose: maps interrupt requests to vector numbers and fetch addresses, places reset and vector table
// Assumes: requests and control inputs come from logic on CLK_SYS_I, the fuse level from outside
// Notes: request bit i belongs to vector i+2; the core clears a request by serving its source

module rivp_top import rivp_pkg::*; #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire rivp_req_t IRQ_REQ_I,
  input wire logic BOOT_RESET_FUSE_I,
  input wire logic VECTOR_MOVE_SELECT_I,
  input wire rivp_addr_t BOOT_RESET_ADDR_I,
  output rivp_addr_t RESET_ADDR_O,
  output rivp_addr_t VEC_START_O,
  output rivp_vec_s IRQ_VEC_O
);

  // ***************************************************************
  // functions
  // ***************************************************************

  function automatic rivp_addr_t vec_offset(input rivp_num_t num);
    rivp_addr_t n;
    n = {{(`RIVP_ADDR_W-6){1'b0}}, num};
    vec_offset = rivp_addr_t'((n - 17'h00001) << 1);
  endfunction

  function automatic rivp_num_t lowest_vec(input rivp_req_t req);
    rivp_num_t v;
    v = 6'h00;
    for (int i = `RIVP_NUM_REQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        v = rivp_num_t'(i) + `RIVP_FIRST_REQ_VEC;
      end
    end
    lowest_vec = v;
  endfunction

  // ***************************************************************
  // fuse synchroniser
  // ***************************************************************

  logic fuse_s1_r;
  logic fuse_s2_r;

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fuse_s1_r <= 1'b1;
      fuse_s2_r <= 1'b1;
    end else if (CE_I) begin
      fuse_s1_r <= BOOT_RESET_FUSE_I;
      fuse_s2_r <= fuse_s1_r;
    end
  end

  // ***************************************************************
  // placement and selection
  // ***************************************************************

  wire rivp_req_t avail_mask = LARGE_VARIANT ? {`RIVP_NUM_REQ{1'b1}} : ~`RIVP_LARGE_ONLY_MASK;
  wire rivp_req_t req_eff = IRQ_REQ_I & avail_mask;
  wire fuse_prog = (fuse_s2_r == `RIVP_FUSE_PROGRAMMED);
  wire rivp_addr_t reset_nxt = fuse_prog ? BOOT_RESET_ADDR_I : `RIVP_APP_RESET_ADDR;
  wire rivp_addr_t origin = VECTOR_MOVE_SELECT_I ? BOOT_RESET_ADDR_I : `RIVP_APP_RESET_ADDR;
  wire rivp_addr_t vec_start_nxt = origin + `RIVP_VEC_START_OFF;
  wire rivp_num_t win_num = lowest_vec(req_eff);
  wire rivp_addr_t win_addr = origin + vec_offset(win_num);
  wire rivp_vec_s vec_nxt = '{valid: |req_eff, num: win_num, addr: win_addr};

  rivp_addr_t reset_addr_r;
  rivp_addr_t vec_start_r;
  rivp_vec_s vec_r;

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      reset_addr_r <= `RIVP_APP_RESET_ADDR;
      vec_start_r <= `RIVP_VEC_START_OFF;
      vec_r <= '0;
    end else if (CE_I) begin
      reset_addr_r <= reset_nxt;
      vec_start_r <= vec_start_nxt;
      vec_r <= vec_nxt;
    end
  end

  assign RESET_ADDR_O = reset_addr_r;
  assign VEC_START_O = vec_start_r;
  assign IRQ_VEC_O = vec_r;

  // ***************************************************************
  // checks
  // ***************************************************************

  wire rivp_addr_t out_off = IRQ_VEC_O.addr - (VEC_START_O - `RIVP_VEC_START_OFF);

  a_vec_spacing: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    IRQ_VEC_O.valid |-> out_off == rivp_addr_t'({IRQ_VEC_O.num - 6'h01, 1'b0}))
    else $error("vector address not two words per vector");

  a_adc_eeprom_vec: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && IRQ_REQ_I[28:0] == '0 && IRQ_REQ_I[29]
    |=> IRQ_VEC_O.num == 6'h1f && out_off == 17'h0003c)
    else $error("data-memory ready not at vector 31");

  a_timer3_vecs: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && IRQ_REQ_I[33:0] == '0 && IRQ_REQ_I[34]
    |=> IRQ_VEC_O.num == 6'h24 && out_off == 17'h00046)
    else $error("timer 3 overflow not at vector 36");

  a_usart1_vecs: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && IRQ_REQ_I[36:0] == '0 && IRQ_REQ_I[37]
    |=> IRQ_VEC_O.num == 6'h27 && out_off == 17'h0004c)
    else $error("serial 1 transmit not at vector 39");

  a_twi_spm_vecs: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && IRQ_REQ_I[38:0] == '0 && IRQ_REQ_I[39]
    |=> IRQ_VEC_O.num == 6'h29 && out_off == 17'h00050)
    else $error("program-store ready not at vector 41");

  a_timer4_vecs: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && LARGE_VARIANT && IRQ_REQ_I[39:0] == '0 && IRQ_REQ_I[40]
    |=> IRQ_VEC_O.num == 6'h2a && out_off == 17'h00052)
    else $error("timer 4 capture not at vector 42");

  a_timer5_vecs: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && IRQ_REQ_I[48:0] == '0 && IRQ_REQ_I[49]
    |=> IRQ_VEC_O.num == 6'h33 && out_off == 17'h00064)
    else $error("timer 5 overflow not at vector 51");

  a_usart23_vecs: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && LARGE_VARIANT && IRQ_REQ_I[54:0] == '0 && IRQ_REQ_I[55]
    |=> IRQ_VEC_O.num == `RIVP_LAST_VEC && out_off == 17'h00070)
    else $error("serial 3 transmit not at vector 57");

  a_small_variant: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !LARGE_VARIANT && IRQ_VEC_O.valid |-> IRQ_VEC_O.num != 6'h2a && IRQ_VEC_O.num != 6'h2f && IRQ_VEC_O.num < 6'h34)
    else $error("absent vector presented in small variant");

  a_boot_reset: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && !fuse_s2_r |=> RESET_ADDR_O == $past(BOOT_RESET_ADDR_I))
    else $error("programmed fuse did not select boot reset address");

  a_move_offset: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && VECTOR_MOVE_SELECT_I && |req_eff
    |=> IRQ_VEC_O.addr == $past(BOOT_RESET_ADDR_I) + vec_offset(IRQ_VEC_O.num))
    else $error("moved vector not at boot start plus offset");

  a_placement_tbl: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I ##1 CE_I && $past(fuse_s2_r) && $past(!VECTOR_MOVE_SELECT_I)
    |-> RESET_ADDR_O == 17'h00000 && VEC_START_O == 17'h00002)
    else $error("default placement not 0x0000 and 0x0002");

  a_ext_wdt_vecs: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && IRQ_REQ_I[10:0] == '0 && IRQ_REQ_I[11]
    |=> IRQ_VEC_O.num == 6'h0d && out_off == 17'h00018)
    else $error("watchdog not at vector 13");

  a_mid_vecs: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && IRQ_REQ_I[11:0] == '0 && IRQ_REQ_I[12]
    |=> IRQ_VEC_O.num == 6'h0e && out_off == 17'h0001a)
    else $error("timer 2 compare A not at vector 14");

  a_lowest_first: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && IRQ_REQ_I[0] |=> IRQ_VEC_O.valid && IRQ_VEC_O.num == `RIVP_FIRST_REQ_VEC)
    else $error("lowest pending vector not presented");

  a_adc_vec: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && IRQ_REQ_I[27:0] == '0 && IRQ_REQ_I[28]
    |=> IRQ_VEC_O.num == 6'h1e && out_off == 17'h0003a)
    else $error("conversion complete not at vector 30");

  a_timer3_capt: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && IRQ_REQ_I[29:0] == '0 && IRQ_REQ_I[30]
    |=> IRQ_VEC_O.num == 6'h20 && out_off == 17'h0003e)
    else $error("timer 3 capture not at vector 32");

  a_serial1_rx: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && IRQ_REQ_I[34:0] == '0 && IRQ_REQ_I[35]
    |=> IRQ_VEC_O.num == 6'h25 && out_off == 17'h00048)
    else $error("serial 1 receive not at vector 37");

  a_two_wire_vec: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && IRQ_REQ_I[37:0] == '0 && IRQ_REQ_I[38]
    |=> IRQ_VEC_O.num == 6'h28 && out_off == 17'h0004e)
    else $error("two-wire event not at vector 40");

  a_timer5_capt: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && LARGE_VARIANT && IRQ_REQ_I[44:0] == '0 && IRQ_REQ_I[45]
    |=> IRQ_VEC_O.num == 6'h2f && out_off == 17'h0005c)
    else $error("timer 5 capture not at vector 47");

  a_serial2_rx: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && LARGE_VARIANT && IRQ_REQ_I[49:0] == '0 && IRQ_REQ_I[50]
    |=> IRQ_VEC_O.num == 6'h34 && out_off == 17'h00066)
    else $error("serial 2 receive not at vector 52");

  a_pin_change_vec: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && IRQ_REQ_I[8:0] == '0 && IRQ_REQ_I[9]
    |=> IRQ_VEC_O.num == 6'h0b && out_off == 17'h00014)
    else $error("pin change 1 not at vector 11");

  a_moved_start: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && VECTOR_MOVE_SELECT_I
    |=> VEC_START_O == $past(BOOT_RESET_ADDR_I) + `RIVP_VEC_START_OFF)
    else $error("moved table start not boot plus 0x0002");

  a_no_pending: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && req_eff == '0
    |=> !IRQ_VEC_O.valid)
    else $error("vector presented with nothing pending");

endmodule

// ===== sim/rivp_core_model.sv
// Purpose: core side model, holds requests and serves the presented vector
// Assumes: same clock as rivp_top
// Notes: a served request drops one edge after its vector shows
module rivp_core_model import rivp_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire rivp_req_t set_i,
  input wire rivp_vec_s vec_i,
  output rivp_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  rivp_req_t req_r;
  rivp_req_t served;
  assign served = vec_i.valid ? (rivp_req_t'(1) << (vec_i.num - 6'h02)) : '0;
  assign req_o = req_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_r <= '0;
    end else begin
      req_r <= (req_r | set_i) & ~served;
    end
  end
endmodule

// ===== sim/rivp_top_tb.sv
// Purpose: self-checking bench for vector mapping and placement
// Assumes: core model serves each presented vector
// Notes: small variant instanced alongside, fed the same requests
module rivp_top_tb import rivp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic rst_n;
  logic fuse;
  logic vms;
  rivp_req_t set;
  rivp_req_t req;
  rivp_addr_t boot;
  rivp_addr_t rst_a;
  rivp_addr_t vst;
  rivp_vec_s vec;
  rivp_vec_s vec_small;
  logic ce;
  int n_fail = 0;
  int checked = 0;
  initial forever #10 clk = ~clk;
  rivp_top u_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .IRQ_REQ_I(req),
    .BOOT_RESET_FUSE_I(fuse), .VECTOR_MOVE_SELECT_I(vms), .BOOT_RESET_ADDR_I(boot),
    .RESET_ADDR_O(rst_a), .VEC_START_O(vst), .IRQ_VEC_O(vec));
  rivp_core_model u_core (.clk_i(clk), .rst_n_i(rst_n), .set_i(set), .vec_i(vec), .req_o(req));
  // small variant watches the same requests, served by the large one
  rivp_top #(.LARGE_VARIANT(1'b0)) u_dut_small (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .IRQ_REQ_I(req),
    .BOOT_RESET_FUSE_I(fuse), .VECTOR_MOVE_SELECT_I(vms), .BOOT_RESET_ADDR_I(boot),
    .RESET_ADDR_O(), .VEC_START_O(), .IRQ_VEC_O(vec_small));
  // ********************
  // tasks
  // ********************
  task automatic report_and_stop;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input rivp_addr_t got, input rivp_addr_t exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_num(input rivp_num_t n);
    int k = 0;
    while (vec.num !== n && k < 10) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (vec.num !== n) begin
      n_fail++;
      $display("wrong value at %0t: no vector %0d", $time, n);
      report_and_stop();
    end
  endtask
  task automatic pulse(input rivp_req_t r);
    @(posedge clk);
    set <= r;
    @(posedge clk);
    set <= '0;
  endtask
  task automatic t_map;
    for (int i = 0; i < 56; i++) begin
      pulse(rivp_req_t'(1) << i);
      wait_num(rivp_num_t'(i + 2));
      chk(rivp_addr_t'(vec.valid), 17'h00001);
      chk(vec.addr, rivp_addr_t'(2 * (i + 1)));
      wait_num(6'h00);
    end
    $display("test map done");
  endtask
  task automatic t_prio;
    pulse((rivp_req_t'(1) << 55) | (rivp_req_t'(1) << 3));
    @(posedge clk);
    #1;
    chk(rivp_addr_t'(vec.num), 17'h00005);
    wait_num(6'h39);
    chk(vec.addr, 17'h00070);
    wait_num(6'h00);
    $display("test priority done");
  endtask
  task automatic t_move;
    @(posedge clk);
    vms <= 1'b1;
    boot <= 17'h1f000;
    pulse(rivp_req_t'(1) << 55);
    wait_num(6'h39);
    chk(vec.addr, 17'h1f070);
    chk(vst, 17'h1f002);
    chk(rst_a, 17'h00000);
    wait_num(6'h00);
    $display("test move done");
  endtask
  task automatic t_fuse;
    @(posedge clk);
    fuse <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(rst_a, 17'h00000);
    @(posedge clk);
    #1;
    chk(rst_a, 17'h1f000);
    chk(vst, 17'h1f002);
    @(posedge clk);
    vms <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(vst, 17'h00002);
    chk(rst_a, 17'h1f000);
    $display("test fuse done");
  endtask
  task automatic t_small;
    pulse((rivp_req_t'(1) << 41) | (rivp_req_t'(1) << 40));
    wait_num(6'h2a);
    chk(rivp_addr_t'(vec_small.num), 17'h0002b);
    chk(vec_small.addr, 17'h00054);
    wait_num(6'h00);
    pulse(rivp_req_t'(1) << 50);
    wait_num(6'h34);
    chk(rivp_addr_t'(vec_small.valid), 17'h00000);
    wait_num(6'h00);
    $display("test small variant done");
  endtask
  task automatic t_freeze;
    pulse(rivp_req_t'(1) << 28);
    wait_num(6'h1e);
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(rivp_addr_t'(vec.num), 17'h0001e);
    chk(vec.addr, 17'h0003a);
    @(posedge clk);
    ce <= 1'b1;
    wait_num(6'h00);
    $display("test freeze done");
  endtask
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    chk(rst_a, 17'h00000);
    chk(vst, 17'h00002);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(rst_a, 17'h00000);
    @(posedge clk);
    #1;
    chk(rst_a, 17'h1f000);
    $display("test reset done");
  endtask
  // ********************
  // main sequence
  // ********************
  initial begin
    rst_n = 1'b0;
    fuse = 1'b1;
    vms = 1'b0;
    ce = 1'b1;
    set = '0;
    boot = '0;
    repeat (4) @(posedge clk);
    #1;
    chk(rst_a, 17'h00000);
    chk(vst, 17'h00002);
    chk(rivp_addr_t'(vec.valid), 17'h00000);
    @(posedge clk);
    rst_n <= 1'b1;
    t_map();
    t_prio();
    t_small();
    t_freeze();
    t_move();
    t_fuse();
    t_reset();
    report_and_stop();
  end
endmodule
